// File: verilog/srp_pkg.sv
// package: constants and types for storage relocation and protection
package srp_pkg;
	localparam int SRP_ADDR_W = 24;
	localparam int SRP_KEY_W = 6;
	localparam int SRP_KEYMEM_DEPTH = 4096;
	localparam int SRP_KEYMEM_AW = 12;
	localparam int SRP_WORD_W = 32;
	// key entry fields (lsb numbering: bit 0 is the lsb of the byte, holding parity)
	localparam int SRP_KEY_CODE_LSB = 2;
	localparam int SRP_KEY_RPF_POS = 1;
	localparam int SRP_KEY_PAR_POS = 0;
	// key memory index: model 8 uses address bits 8..20, large model bits 8..19
	localparam int SRP_M8_IDX_LSB = 3;
	localparam int SRP_LG_IDX_LSB = 4;
	// relocation value counts 2048-byte units
	localparam int SRP_RELOC_SHIFT = 11;
	// status word key fields: psw bits 8..11 and 20..21 in machine numbering
	localparam int SRP_PSW_KEYHI_LSB = 20;
	localparam int SRP_PSW_KEYLO_LSB = 10;
	localparam int SRP_PSW_IA_W = 24;
	localparam logic [23:0] SRP_RESET_IA = 24'h00_0000;
	localparam logic [23:0] SRP_RESET_RELOC = 24'h00_0000;
	localparam logic [7:0] SRP_RESET_KEY = 8'h00;
	typedef enum logic [1:0] {SRP_REQ_CPU, SRP_REQ_TABLER, SRP_REQ_CHAN} srp_req_t;
	typedef enum logic [2:0] {
		SRP_OP_NONE, SRP_OP_INTR, SRP_OP_LPSW, SRP_OP_SETKEY, SRP_OP_INSKEY
	} srp_op_t;
	typedef enum logic [1:0] {SRP_A_REL, SRP_A_NOREL, SRP_A_INSTR} srp_akind_t;
endpackage

// File: verilog/srp_key_if.sv
// interface: key memory port between the top and its key store
`timescale 1ns/1ps
interface srp_key_if;
	import srp_pkg::*;
	logic [SRP_KEYMEM_AW-1:0] addr;
	logic wrEn;
	logic [7:0] wrData;
	logic [7:0] rdData;
	modport owner (output addr, output wrEn, output wrData, input rdData);
	modport store (input addr, input wrEn, input wrData, output rdData);
endinterface

// File: verilog/srp_key_mem.sv
// key memory: one byte per storage block, registered read
`timescale 1ns/1ps
module srp_key_mem (
	// clock
	input wire logic mclk,
	// port
	srp_key_if.store kp
);
	import srp_pkg::*;
	logic [7:0] mem [SRP_KEYMEM_DEPTH];
	logic [7:0] rdQ;
	// no reset on the array: keys are set by the supervisor before use
	always_ff @(posedge mclk) begin
		if (kp.wrEn) begin
			mem[kp.addr] <= kp.wrData;
		end
		rdQ <= mem[kp.addr];
	end
	assign kp.rdData = rdQ;
endmodule

// File: verilog/srp_addr_gen.sv
// address generation: relative to absolute with relocation and index
`timescale 1ns/1ps
module srp_addr_gen #(
	parameter bit LARGE_MODEL = 1'b0
) (
	// operands
	input wire logic [23:0] base,
	input wire logic [11:0] disp,
	input wire logic [23:0] index,
	input wire logic useIndex,
	input wire logic [23:0] reloc,
	input wire logic applyReloc,
	// result
	output logic [23:0] absAddr,
	output logic [23:0] relAddr
);
	import srp_pkg::*;
	logic [23:0] offs;
	logic [23:0] idx;
	always_comb begin
		// low 11 bits of the relocation value are added as zero
		offs = applyReloc ? {reloc[23:SRP_RELOC_SHIFT], 11'h000} : 24'h00_0000;
		idx = useIndex ? index : 24'h00_0000;
		relAddr = 24'(base + {12'h000, disp} + idx);
		// modular add makes index placement a carry-free choice; both forms kept explicit
		if (LARGE_MODEL) begin
			absAddr = 24'(idx + (24'(base + {12'h000, disp}) + offs));
		end else begin
			absAddr = 24'(24'(base + {12'h000, disp} + offs) + idx);
		end
	end
endmodule

// File: verilog/srp_top.sv
// top: storage relocation, key memory and protection check
`timescale 1ns/1ps
module srp_top #(
	parameter bit LARGE_MODEL = 1'b0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// status word control
	input wire srp_pkg::srp_op_t op,
	input wire logic [31:0] newPswWord,
	input wire logic [23:0] newRelocValue,
	input wire logic supervisorMode,
	input wire logic unrelocatedMode,
	// storage access request
	input wire logic reqValid,
	input wire srp_pkg::srp_req_t reqSource,
	input wire srp_pkg::srp_akind_t addrKind,
	input wire logic reqWrite,
	input wire logic [23:0] reqBase,
	input wire logic [11:0] reqDisp,
	input wire logic [23:0] reqIndex,
	input wire logic reqUseIndex,
	input wire logic [5:0] ioKey,
	// key instructions
	input wire logic [23:0] keyAddr,
	input wire logic [7:0] keyWrData,
	// main storage side
	input wire logic [31:0] storeRdData,
	input wire logic storeRdValid,
	// outputs
	output logic [31:0] currentPsw,
	output logic [23:0] oldPswAddr,
	output logic [23:0] currentReloc,
	output logic [5:0] relocSelect,
	output logic relocFetch,
	output logic [23:0] memAddr,
	output logic memReadEn,
	output logic memWriteEn,
	output logic [31:0] rdData,
	output logic rdValid,
	output logic protException,
	output logic programIntReq,
	output logic privException,
	output logic [7:0] keyRdData,
	output logic keyRdValid
);
	import srp_pkg::*;

	typedef struct packed {
		logic [31:0] program_status_word;
		logic [23:0] oldIa;
		logic [23:0] reloc;
		logic [5:0] relocSel;
		logic relocFetch;
		logic relocPending;
		logic chkPending;
		logic chkWrite;
		logic chkProgram;
		logic [5:0] chkKey;
		logic [23:0] chkAddr;
		// verdicts of reads still out at storage, oldest in bit 0
		logic [3:0] denyQ;
		logic [2:0] denyCnt;
		logic [23:0] memAddr;
		logic memReadEn;
		logic memWriteEn;
		logic [31:0] rdData;
		logic rdValid;
		logic protExc;
		logic progInt;
		logic privExc;
		logic iskPending;
		logic [7:0] keyRd;
		logic keyRdValid;
	} srp_state_t;

	srp_state_t cur;
	srp_state_t nxt;
	srp_key_if kif ();
	logic [23:0] absAddr;
	logic [23:0] relAddr;
	logic doReloc;

	function automatic logic [5:0] psw_key(input logic [31:0] w);
		// machine bits 8..11 and 20..21 map to lsb-numbered 23..20 and 11..10
		return {w[SRP_PSW_KEYHI_LSB +: 4], w[SRP_PSW_KEYLO_LSB +: 2]};
	endfunction

	function automatic logic [11:0] key_index(input logic [23:0] a);
		if (LARGE_MODEL) begin
			return a[SRP_LG_IDX_LSB + 8 +: 12];
		end
		// model 8: bits 8..20 give 13 bits; only 4096 keys exist, top bit dropped
		return a[SRP_M8_IDX_LSB + 8 +: 12];
	endfunction

	function automatic logic parity(input logic [6:0] v);
		return ~^v;
	endfunction

	// relocation is skipped for channel and tabler requests, no-relocate operands and unrelocated mode
	assign doReloc = (reqSource == SRP_REQ_CPU) && (addrKind != SRP_A_NOREL)
		&& !unrelocatedMode;

	srp_addr_gen #(
		.LARGE_MODEL(LARGE_MODEL)
	) u_agen (
		.base(reqBase),
		.disp(reqDisp),
		.index(reqIndex),
		.useIndex(reqUseIndex && addrKind != SRP_A_INSTR),
		.reloc(cur.reloc),
		.applyReloc(doReloc),
		.absAddr(absAddr),
		.relAddr(relAddr)
	);

	srp_key_mem u_keys (
		.mclk(mclk),
		.kp(kif.store)
	);

	always_comb begin
		logic [5:0] reqKey;
		logic keyMatch;
		logic allow;
		logic [3:0] next_denyQ;
		logic [2:0] next_denyCnt;
		reqKey = 6'h00;
		keyMatch = 1'b0;
		allow = 1'b0;
		next_denyQ = cur.denyQ;
		next_denyCnt = cur.denyCnt;
		nxt = cur;
		nxt.relocFetch = 1'b0;
		nxt.memReadEn = 1'b0;
		nxt.memWriteEn = 1'b0;
		nxt.rdValid = 1'b0;
		nxt.protExc = 1'b0;
		nxt.progInt = 1'b0;
		nxt.privExc = 1'b0;
		nxt.keyRdValid = 1'b0;
		nxt.iskPending = 1'b0;
		nxt.chkPending = 1'b0;
		kif.addr = key_index(absAddr);
		kif.wrEn = 1'b0;
		kif.wrData = 8'h00;

		// status word changes and key instructions
		unique case (op)
			SRP_OP_INTR: begin
				nxt.oldIa = cur.program_status_word[SRP_PSW_IA_W-1:0];
				nxt.program_status_word = newPswWord;
				nxt.relocSel = psw_key(newPswWord);
				nxt.relocFetch = 1'b1;
				nxt.relocPending = 1'b1;
			end
			SRP_OP_LPSW: begin
				nxt.program_status_word = newPswWord;
				nxt.relocSel = psw_key(newPswWord);
				nxt.relocFetch = 1'b1;
				nxt.relocPending = 1'b1;
			end
			SRP_OP_SETKEY: begin
				kif.addr = key_index(keyAddr);
				if (supervisorMode) begin
					kif.wrEn = 1'b1;
					kif.wrData = {keyWrData[7:1], parity(keyWrData[7:1])};
				end else begin
					nxt.privExc = 1'b1;
				end
			end
			SRP_OP_INSKEY: begin
				kif.addr = key_index(keyAddr);
				if (supervisorMode) begin
					nxt.iskPending = 1'b1;
				end else begin
					nxt.privExc = 1'b1;
				end
			end
			SRP_OP_NONE: begin
			end
		endcase

		// the relocation word is supplied one cycle after the fetch strobe
		if (cur.relocPending && !cur.relocFetch) begin
			nxt.reloc = newRelocValue;
			nxt.relocPending = 1'b0;
		end

		if (cur.iskPending) begin
			nxt.keyRd = {kif.rdData[7:1], 1'b0};
			nxt.keyRdValid = 1'b1;
		end

		// new access: key read starts this cycle, check next cycle
		if (reqValid && op != SRP_OP_SETKEY && op != SRP_OP_INSKEY) begin
			unique case (reqSource)
				SRP_REQ_CPU: nxt.chkKey = psw_key(cur.program_status_word);
				SRP_REQ_TABLER: nxt.chkKey = ioKey;
				SRP_REQ_CHAN: nxt.chkKey = ioKey;
			endcase
			nxt.chkPending = 1'b1;
			nxt.chkWrite = reqWrite;
			nxt.chkProgram = (reqSource == SRP_REQ_CPU);
			nxt.chkAddr = absAddr;
		end

		if (cur.chkPending) begin
			reqKey = cur.chkKey;
			keyMatch = (kif.rdData[7:SRP_KEY_CODE_LSB] == reqKey);
			if (cur.chkWrite) begin
				allow = keyMatch || (reqKey == 6'h00);
			end else begin
				allow = keyMatch || (reqKey == 6'h00)
					|| !kif.rdData[SRP_KEY_RPF_POS];
			end
			nxt.memAddr = cur.chkAddr;
			nxt.memWriteEn = cur.chkWrite && allow;
			// reads go out even when denied; the data is blocked on return
			nxt.memReadEn = !cur.chkWrite;
			nxt.protExc = !allow;
			nxt.progInt = !allow && cur.chkProgram;
		end

		// reads return in issue order, so each return takes the oldest verdict;
		// a single flag would be overwritten by back-to-back requests
		// depth four covers the storage latencies this block expects
		if (storeRdValid) begin
			nxt.rdValid = !next_denyQ[0];
			nxt.rdData = next_denyQ[0] ? 32'h0000_0000 : storeRdData;
			if (next_denyCnt != 3'h0) begin
				next_denyQ = {1'b0, next_denyQ[3:1]};
				next_denyCnt = next_denyCnt - 3'h1;
			end
		end
		// a read leaving for storage queues its own verdict behind older ones
		if (cur.chkPending && !cur.chkWrite) begin
			next_denyQ[next_denyCnt[1:0]] = !allow;
			next_denyCnt = next_denyCnt + 3'h1;
		end
		nxt.denyQ = next_denyQ;
		nxt.denyCnt = next_denyCnt;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	assign currentPsw = cur.program_status_word;
	assign oldPswAddr = cur.oldIa;
	assign currentReloc = cur.reloc;
	assign relocSelect = cur.relocSel;
	assign relocFetch = cur.relocFetch;
	assign memAddr = cur.memAddr;
	assign memReadEn = cur.memReadEn;
	assign memWriteEn = cur.memWriteEn;
	assign rdData = cur.rdData;
	assign rdValid = cur.rdValid;
	assign protException = cur.protExc;
	assign programIntReq = cur.progInt;
	assign privException = cur.privExc;
	assign keyRdData = cur.keyRd;
	assign keyRdValid = cur.keyRdValid;
endmodule

// File: tb/srp_top_chk.sv
// checker: timing relations at the top ports
`timescale 1ns/1ps
module srp_top_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// requests
	input wire srp_pkg::srp_op_t op,
	input wire logic supervisorMode,
	input wire logic [31:0] newPswWord,
	input wire logic [23:0] newRelocValue,
	input wire logic reqValid,
	// answers
	input wire logic [31:0] currentPsw,
	input wire logic [23:0] oldPswAddr,
	input wire logic [23:0] currentReloc,
	input wire logic relocFetch,
	input wire logic memReadEn,
	input wire logic memWriteEn,
	input wire logic protException,
	input wire logic programIntReq,
	input wire logic privException
);
	import srp_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	sequence newStatus;
		op == SRP_OP_INTR || op == SRP_OP_LPSW;
	endsequence
	sequence accTaken;
		reqValid && op == SRP_OP_NONE;
	endsequence
	sequence keyOp;
		op == SRP_OP_SETKEY || op == SRP_OP_INSKEY;
	endsequence
	psw_load_a: assert property (newStatus |=> currentPsw == $past(newPswWord))
		else $error("status word not loaded");
	old_addr_a: assert property (op == SRP_OP_INTR |=> oldPswAddr == 24'($past(currentPsw)))
		else $error("old address not saved");
	reloc_fetch_a: assert property (newStatus |=> relocFetch)
		else $error("no relocation fetch");
	reloc_load_a: assert property (relocFetch |-> ##2 currentReloc == $past(newRelocValue))
		else $error("relocation not loaded");
	access_answer_a: assert property (accTaken |-> ##2 (memReadEn || memWriteEn || protException))
		else $error("access not answered");
	write_block_a: assert property (protException |-> !memWriteEn)
		else $error("denied write reached storage");
	int_cause_a: assert property (programIntReq |-> protException)
		else $error("interrupt without exception");
	priv_check_a: assert property (keyOp ##0 !supervisorMode |=> privException)
		else $error("key op outside supervisor");
endmodule
bind srp_top srp_top_chk chk_u (.*);

// File: tb/srp_store_model.sv
// partner: main storage read returns and relocation register area
`timescale 1ns/1ps
module srp_store_model (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// pacing
	input wire logic slowMode,
	// requests
	input wire logic [23:0] memAddr,
	input wire logic memReadEn,
	input wire logic relocFetch,
	input wire logic [5:0] relocSelect,
	// answers
	output logic [31:0] storeRdData,
	output logic storeRdValid,
	output logic [23:0] newRelocValue
);
	logic [1:0] vld;
	logic relAns;
	logic [23:0] a1, a2;
	// read cycle runs even when the access is denied; dropping it is the block's job
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			vld <= 2'h0;
			relAns <= 1'b0;
		end else begin
			vld <= {vld[0], memReadEn};
			relAns <= relocFetch;
		end
		a1 <= memAddr;
		a2 <= a1;
	end
	assign storeRdValid = slowMode ? vld[1] : vld[0];
	assign storeRdData = storeRdValid ? {8'h00, slowMode ? a2 : a1} : ~{8'h00, a1};
	// low bits deliberately nonzero so the block must mask them
	// the register word answers in the cycle after the fetch strobe
	assign newRelocValue = relAns ? {relocSelect, 7'h2A, 11'h5A5} : ~{relocSelect, 18'h0_0000};
endmodule

// File: tb/tb_top.sv
// testbench: key memory, status loads and protected accesses
`timescale 1ns/1ps
module tb_top;
	import srp_pkg::*;
	logic mclk = 0, reset = 1, supervisorMode = 1, unrelocatedMode = 0, slowMode = 0;
	srp_op_t op = SRP_OP_NONE;
	srp_req_t reqSource = SRP_REQ_CPU;
	srp_akind_t addrKind = SRP_A_REL;
	logic reqValid = 0, reqWrite = 0, reqUseIndex = 0, pendRd = 0;
	logic [1:0] pendRel = 0;
	logic [31:0] newPswWord = 0, currentPsw, storeRdData, rdData, curPsw = 0;
	logic [23:0] reqBase = 0, reqIndex = 0, keyAddr = 0, curOld = 0, curReloc = 0;
	logic [23:0] newRelocValue, oldPswAddr, currentReloc, memAddr;
	logic [11:0] reqDisp = 0;
	logic [7:0] keyWrData = 0, keyRdData, kyQ[$], keys[8];
	logic [5:0] ioKey = 0, curKey = 0, relocSelect;
	logic storeRdValid, relocFetch, memReadEn, memWriteEn, rdValid;
	logic protException, programIntReq, privException, keyRdValid;
	logic [85:0] stQ[$], stE;
	logic [27:0] acQ[$], acE, acG;
	logic [32:0] rdQ[$], rdE;
	logic [15:0] rnd = 16'h0055;
	int errors = 0, compares = 0;
	localparam logic [11:0] BLK[8] = '{12'h000, 12'h001, 12'h002, 12'h064, 12'h7FF, 12'h800,
		12'hFFE, 12'hFFF};
	srp_top #(.LARGE_MODEL(1'b0)) dut_u (.*);
	srp_store_model mem_u (.*);
	initial forever #2.5 mclk = ~mclk;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string nm, input logic [85:0] e, input logic [85:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic keyop(input srp_op_t o, input int b, input logic [7:0] d);
		@(negedge mclk);
		op = o;
		keyAddr = {rnd[0], BLK[b], rnd[11:1]};
		keyWrData = d;
		if (supervisorMode && o == SRP_OP_SETKEY) keys[b] = {d[7:1], 1'b0};
		if (supervisorMode && o == SRP_OP_INSKEY) kyQ.push_back(keys[b]);
		@(negedge mclk);
		op = SRP_OP_NONE;
		@(negedge mclk);
	endtask
	task automatic status(input srp_op_t o, input logic [5:0] k);
		logic [31:0] w;
		rnd = lfsr(rnd);
		w = {rnd[7:0], k[5:2], rnd[15:8], k[1:0], rnd[9:0]};
		if (o == SRP_OP_INTR) curOld = curPsw[23:0];
		curPsw = w;
		curKey = k;
		curReloc = {k, 7'h2A, 11'h5A5};
		stQ.push_back({k, w, curOld, curReloc});
		@(negedge mclk);
		op = o;
		newPswWord = w;
		@(negedge mclk);
		op = SRP_OP_NONE;
		repeat (3) @(negedge mclk);
	endtask
	task automatic access(input srp_req_t s, input srp_akind_t k, input logic w, input int b,
		input logic [5:0] ik);
		logic [23:0] unrelocated_mode, off, ix;
		logic [5:0] rq;
		logic ok, deny;
		rnd = lfsr(rnd);
		unrelocated_mode = {rnd[0], BLK[b], rnd[11:1]};
		ok = s == SRP_REQ_CPU && k != SRP_A_NOREL && !unrelocatedMode;
		off = ok ? curReloc & 24'hFF_F800 : 24'h00_0000;
		ix = (k != SRP_A_INSTR && rnd[2]) ? {rnd, rnd[7:0]} : 24'h00_0000;
		rq = s == SRP_REQ_CPU ? curKey : ik;
		ok = rq == keys[b][7:2] || rq == 6'h00;
		deny = w ? !ok : !(ok || !keys[b][1]);
		acQ.push_back({deny && s == SRP_REQ_CPU, deny, w && !deny, !w, unrelocated_mode});
		if (!w) rdQ.push_back({!deny, 8'h00, unrelocated_mode});
		@(negedge mclk);
		reqValid = 1;
		reqSource = s;
		addrKind = k;
		reqWrite = w;
		ioKey = ik;
		reqDisp = rnd[15:4];
		reqIndex = {rnd, rnd[7:0]};
		reqUseIndex = rnd[2];
		reqBase = unrelocated_mode - {12'h000, rnd[15:4]} - off - ix;
	endtask
	always @(negedge mclk) begin
		if (memReadEn || memWriteEn || protException) begin
			acE = acQ.size() ? acQ.pop_front() : 'x;
			acG = {programIntReq, protException, memWriteEn, memReadEn, memAddr};
			if (!(memReadEn || memWriteEn)) acG[23:0] = acE[23:0];
			chk("access", acE, acG);
		end
		if (pendRd) begin
			rdE = rdQ.size() ? rdQ.pop_front() : 'x;
			chk("read", rdE, {rdValid, rdValid ? rdData : rdE[31:0]});
		end
		pendRd = storeRdValid;
		if (keyRdValid) chk("key", kyQ.size() ? kyQ.pop_front() : 'x, keyRdData);
		// relocation lands two cycles after the fetch strobe
		if (pendRel[1]) chk("reloc", stE[23:0], currentReloc);
		pendRel = {pendRel[0], relocFetch};
		if (relocFetch) begin
			stE = stQ.size() ? stQ.pop_front() : 'x;
			chk("status", stE[85:24], {relocSelect, currentPsw, oldPswAddr});
		end
	end
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		finish_test();
	end
	initial begin
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		reset = 0;
		chk("reset", 56'h00_0000_0000_0000, {currentPsw, currentReloc});
		for (int i = 0; i < 8; i++) keyop(SRP_OP_SETKEY, i, {6'(i * 9 + 1), i[0], rnd[0]});
		supervisorMode = 0;
		keyop(SRP_OP_SETKEY, 0, 8'hFF);
		keyop(SRP_OP_INSKEY, 0, 8'h00);
		supervisorMode = 1;
		for (int i = 0; i < 8; i++) keyop(SRP_OP_INSKEY, i, 8'h00);
		$display("key test done");
		for (int r = 0; r < 12; r++) begin
			slowMode = r[2];
			unrelocatedMode = r == 5;
			status(r[1] ? SRP_OP_LPSW : SRP_OP_INTR, r % 4 == 3 ? 6'h00 : 6'((r % 8) * 9 + 1));
			for (int j = 0; j < 6; j++) begin
				access(srp_req_t'(rnd[1:0] % 3), srp_akind_t'(rnd[3:2] % 3), rnd[4], rnd[7:5],
					rnd[8] ? 6'(rnd[7:5] * 9 + 1) : rnd[14:9]);
			end
			@(negedge mclk);
			reqValid = 0;
			repeat (6) @(negedge mclk);
			$display("access round %0d done", r);
		end
		for (int t = 0; t < 50 && acQ.size() + rdQ.size() + kyQ.size() + stQ.size() > 0; t++)
			@(negedge mclk);
		if (acQ.size() + rdQ.size() + kyQ.size() + stQ.size() > 0) errors++;
		finish_test();
	end
endmodule
